//--- rtl/device_id_and_checksum.sv
// Identity words and program-image checksum accumulator.
`default_nettype none
module device_id_and_checksum #(
    parameter logic [7:0] family_code = 8'h5a, // Value is arbitrary.
    parameter logic [7:0] part_code = 8'h3c, // Value is arbitrary.
    parameter logic [3:0] stepping_code = 4'h1, // Value is arbitrary.
    parameter bit large_part = 1'b0
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire identity_word_pkg::read_req_s code_read_command,
    output identity_word_pkg::read_rsp_s read_rsp,
    input wire logic read_protect,
    input wire logic sum_clear,
    input wire logic code_word_valid,
    input wire logic [23:0] code_word_addr,
    input wire logic [23:0] code_word_data,
    output logic [23:0] last_code_addr,
    output logic [15:0] checksum
);
    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    // The stepping field must fit the low nibble that the second word exposes.
    if (identity_word_pkg::stepping_width != 4) begin : g_bad_stepping
        $error("stepping field width must be four bits");
    end
    // The family and part fields must fill the high and low bytes exactly.
    if (identity_word_pkg::family_lsb != 8 || identity_word_pkg::part_lsb != 0) begin : g_bad_layout
        $error("identity fields must fill the high and low bytes");
    end

    // ----------------------------------------------------------------
    // Identity words
    // ----------------------------------------------------------------
    logic [15:0] identity_word;
    logic [15:0] stepping_word;
    identity_word_pkg::read_rsp_s read_rsp_q;

    assign identity_word = {family_code, part_code};
    assign stepping_word = {12'h000, stepping_code};

    // Protection is deliberately not consulted: identity stays visible.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            read_rsp_q <= '{valid: 1'b0, data: identity_word_pkg::reset_read_data, hit: 1'b0};
        end else begin
            read_rsp_q.valid <= code_read_command.valid;
            if (code_read_command.valid &&
                code_read_command.addr == identity_word_pkg::identity_word_addr) begin
                read_rsp_q.data <= identity_word;
                read_rsp_q.hit <= 1'b1;
            end else if (code_read_command.valid &&
                         code_read_command.addr == identity_word_pkg::stepping_word_addr) begin
                read_rsp_q.data <= stepping_word;
                read_rsp_q.hit <= 1'b1;
            end else if (code_read_command.valid) begin
                read_rsp_q.data <= identity_word_pkg::reset_read_data;
                read_rsp_q.hit <= 1'b0;
            end
        end
    end
    assign read_rsp = read_rsp_q;

    // ----------------------------------------------------------------
    // Checksum accumulation
    // ----------------------------------------------------------------
    logic [23:0] last_addr;
    logic is_code;
    logic is_cw1;
    logic is_cw;
    logic [15:0] cw_masked;
    logic [15:0] add_d;
    logic [15:0] sum_q;

    assign last_addr = large_part ? identity_word_pkg::last_code_large : identity_word_pkg::last_code_small;
    assign last_code_addr = last_addr;
    assign is_code = code_word_addr <= last_addr;
    assign is_cw1 = code_word_addr == last_addr;
    // Configuration slots lie inside the code range, so they count twice:
    // once as three code bytes and once as their masked lower two bytes.
    assign is_cw = is_cw1 || code_word_addr == last_addr - 24'd2 ||
                   code_word_addr == last_addr - 24'd4 ||
                   code_word_addr == last_addr - 24'd6;
    assign cw_masked = code_word_data[15:0] &
                       (is_cw1 ? identity_word_pkg::cw1_mask : identity_word_pkg::cw_mask);

    always_comb begin
        add_d = 16'h0000;
        if (is_code) begin
            add_d = add_d + {8'h00, code_word_data[7:0]} + {8'h00, code_word_data[15:8]}
                    + {8'h00, code_word_data[23:16]};
        end
        if (is_cw) begin
            add_d = add_d + {8'h00, cw_masked[7:0]} + {8'h00, cw_masked[15:8]};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn || sum_clear) begin
            sum_q <= identity_word_pkg::reset_sum;
        end else if (code_word_valid) begin
            sum_q <= sum_q + add_d;
        end
    end
    assign checksum = read_protect ? 16'h0000 : sum_q;

    // ----------------------------------------------------------------
    // Read response sequences
    // ----------------------------------------------------------------
    // An identity read is a request in one cycle and a hit answer in the next.
    sequence s_id_request;
        code_read_command.valid && code_read_command.addr == identity_word_pkg::identity_word_addr;
    endsequence

    sequence s_id_answer;
        read_rsp.valid && read_rsp.hit && read_rsp.data == {family_code, part_code};
    endsequence

    sequence s_miss_request;
        code_read_command.valid && code_read_command.addr != identity_word_pkg::identity_word_addr
        && code_read_command.addr != identity_word_pkg::stepping_word_addr;
    endsequence

    sequence s_miss_answer;
        read_rsp.valid && !read_rsp.hit && read_rsp.data == 16'h0000;
    endsequence

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_id_read_data: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_id_request |=> s_id_answer)
        else $error("identity word read wrong");

    a_miss_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_miss_request |=> s_miss_answer)
        else $error("unmapped read not answered with zero");

    a_data_holds: assert property (@(posedge clk_sys) disable iff (!rstn)
        !code_read_command.valid
        |=> !read_rsp.valid && $stable(read_rsp.data) && $stable(read_rsp.hit))
        else $error("read answer changed without a request");

    a_step_read_data: assert property (@(posedge clk_sys) disable iff (!rstn)
        code_read_command.valid && code_read_command.addr == identity_word_pkg::stepping_word_addr
        |=> read_rsp.hit && read_rsp.data[15:4] == 12'h000
            && read_rsp.data[3:0] == stepping_code)
        else $error("stepping word read wrong");
    a_id_protected: assert property (@(posedge clk_sys) disable iff (!rstn)
        read_protect && code_read_command.valid
        && code_read_command.addr == identity_word_pkg::identity_word_addr
        |=> read_rsp.hit && read_rsp.data == {family_code, part_code})
        else $error("identity hidden by protection");

    a_step_protected: assert property (@(posedge clk_sys) disable iff (!rstn)
        read_protect && code_read_command.valid
        && code_read_command.addr == identity_word_pkg::stepping_word_addr
        |=> read_rsp.hit && read_rsp.data == {12'h000, stepping_code})
        else $error("stepping word hidden by protection");

    a_resp_follows: assert property (@(posedge clk_sys) disable iff (!rstn)
        read_rsp.valid == $past(code_read_command.valid))
        else $error("response valid not one cycle after request");

    a_code_bytes: assert property (@(posedge clk_sys) disable iff (!rstn)
        is_code && !is_cw |-> add_d == 16'({8'h00, code_word_data[7:0]}
            + {8'h00, code_word_data[15:8]} + {8'h00, code_word_data[23:16]}))
        else $error("code word bytes not summed");

    a_cw_bytes: assert property (@(posedge clk_sys) disable iff (!rstn)
        is_cw && !is_cw1 |-> add_d == 16'({8'h00, code_word_data[7:0]}
            + {8'h00, code_word_data[15:8]} + {8'h00, code_word_data[23:16]}
            + {8'h00, code_word_data[7:0]} + {8'h00, code_word_data[15:8]}))
        else $error("configuration word bytes not summed");

    a_cw_in_range: assert property (@(posedge clk_sys) disable iff (!rstn)
        is_cw |-> is_code)
        else $error("configuration slot outside code range");

    a_clear_wins: assert property (@(posedge clk_sys) disable iff (!rstn)
        sum_clear && code_word_valid |=> sum_q == 16'h0000)
        else $error("clear lost against a word");

    a_sum_protect: assert property (@(posedge clk_sys) disable iff (!rstn)
        read_protect |-> checksum == 16'h0000)
        else $error("checksum visible under protection");

    a_sum_wraps: assert property (@(posedge clk_sys) disable iff (!rstn)
        code_word_valid && !sum_clear |=> sum_q == 16'($past(sum_q) + $past(add_d)))
        else $error("checksum did not accumulate");

    a_out_of_range: assert property (@(posedge clk_sys) disable iff (!rstn)
        code_word_valid && !sum_clear && code_word_addr > last_addr
        |=> $stable(sum_q))
        else $error("address past code range summed");

    a_cw1_bit15: assert property (@(posedge clk_sys) disable iff (!rstn)
        is_cw1 |-> add_d == 16'({8'h00, code_word_data[7:0]} + {8'h00, code_word_data[15:8]}
            + {8'h00, code_word_data[23:16]} + {8'h00, code_word_data[7:0]}
            + {9'h000, code_word_data[14:8]}))
        else $error("first configuration word mask wrong");

    a_clear_sum: assert property (@(posedge clk_sys) disable iff (!rstn)
        sum_clear |=> sum_q == 16'h0000 ##1 1'b1)
        else $error("clear did not zero checksum");
endmodule // device_id_and_checksum
`default_nettype wire

//--- include/identity_word_pkg.sv
// Package with the identity map, field layouts and checksum constants.
`default_nettype none
package identity_word_pkg;
    localparam logic [23:0] identity_word_addr = 24'hff0000;
    localparam logic [23:0] stepping_word_addr = 24'hff0002;
    localparam int family_lsb = 8;
    localparam int part_lsb = 0;
    localparam int stepping_lsb = 0;
    localparam int stepping_width = 4;
    localparam logic [23:0] last_code_small = 24'h0057f7;
    localparam logic [23:0] last_code_large = 24'h00abf7;
    localparam logic [15:0] cw1_mask = 16'h7fff;
    localparam logic [15:0] cw_mask = 16'hffff;
    localparam logic [15:0] reset_read_data = 16'h0000;
    localparam logic [15:0] reset_sum = 16'h0000;

    typedef struct packed {
        logic valid;
        logic [23:0] addr;
    } read_req_s;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
        logic hit;
    } read_rsp_s;
endpackage
`default_nettype wire

//--- verification/programmer_model.sv
// Programmer model that streams program words into the checksum port.
`default_nettype none
module programmer_model (
    input wire logic clk_sys,
    input wire logic start,
    input wire logic [23:0] stop_addr,
    output logic word_valid,
    output logic [23:0] word_addr,
    output logic [23:0] word_data
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        word_valid = 1'b0;
        word_addr = 24'h000000;
        word_data = 24'h000000;
        @(posedge start);
        for (int a = 0; a <= int'(stop_addr); a++) begin
            @(posedge clk_sys);
            #1;
            word_valid = 1'b1;
            word_addr = 24'(a);
            word_data = 24'($urandom);
        end
        @(posedge clk_sys);
        #1;
        word_valid = 1'b0;
        word_data = ~word_data;
    end
endmodule // programmer_model
`default_nettype wire

//--- verification/device_id_and_checksum_tb.sv
// Self-checking bench for the identity words and checksum accumulator.
`default_nettype none
module device_id_and_checksum_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [23:0] last = identity_word_pkg::last_code_small;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic prot = 1'b0;
    logic clr = 1'b0;
    logic start = 1'b0;
    logic cw_valid;
    logic [23:0] cw_addr, cw_data, last_addr;
    logic [23:0] last_large;
    logic [15:0] checksum;
    logic [15:0] exp_sum = 16'h0000;
    identity_word_pkg::read_req_s cmd = '0;
    identity_word_pkg::read_rsp_s rsp;
    logic [16:0] notes[$];
    int n_mismatch = 0;
    int tests_run = 0;
    always #10 clk_sys = ~clk_sys;
    device_id_and_checksum dut (.clk_sys(clk_sys), .rstn(rstn), .code_read_command(cmd),
        .read_rsp(rsp), .read_protect(prot), .sum_clear(clr), .code_word_valid(cw_valid),
        .code_word_addr(cw_addr), .code_word_data(cw_data), .last_code_addr(last_addr),
        .checksum(checksum));
    device_id_and_checksum #(.large_part(1'b1)) dut_large (.clk_sys(clk_sys), .rstn(rstn),
        .code_read_command(cmd), .read_rsp(), .read_protect(prot), .sum_clear(clr),
        .code_word_valid(1'b0), .code_word_addr(24'h000000), .code_word_data(24'h000000),
        .last_code_addr(last_large), .checksum());
    programmer_model partner (.clk_sys(clk_sys), .start(start), .stop_addr(last + 24'h1),
        .word_valid(cw_valid), .word_addr(cw_addr), .word_data(cw_data));
    function automatic logic [15:0] add_of(logic [23:0] a, logic [23:0] d);
        logic [15:0] s;
        s = 16'h0000;
        if (a <= last) s = d[23:16] + d[15:8] + d[7:0];
        if (a == last) s = s + (d[15:8] & 8'h7f) + d[7:0];
        else if (a inside {last - 2, last - 4, last - 6}) s = s + d[15:8] + d[7:0];
        return s;
    endfunction
    always @(posedge clk_sys) begin
        if (clr) exp_sum <= 16'h0000;
        else if (cw_valid) exp_sum <= exp_sum + add_of(cw_addr, cw_data);
    end
    task automatic check(logic [23:0] got, logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(logic [23:0] a, logic [16:0] e);
        @(posedge clk_sys);
        #1;
        cmd = '{1'b1, a};
        notes.push_back(e);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(negedge clk_sys) begin
        if (rsp.valid === 1'b1) check(24'({rsp.data, rsp.hit}), 24'(notes.pop_front()));
    end
    initial begin
        int k;
        void'($urandom(32'h5ee1));
        repeat (16) @(posedge clk_sys);
        #1;
        rstn = 1'b1;
        check(24'(checksum), 24'h0);
        check(last_addr, last);
        check(last_large, identity_word_pkg::last_code_large);
        for (int p = 0; p < 2; p++) begin
            prot = p[0];
            rd(identity_word_pkg::identity_word_addr, {16'h5a3c, 1'b1});
            rd(identity_word_pkg::stepping_word_addr, {16'h0001, 1'b1});
            rd(24'hff0004, 17'h0);
        end
        @(posedge clk_sys);
        #1;
        cmd = '0;
        prot = 1'b0;
        start = 1'b1;
        k = 0;
        while (!(cw_valid === 1'b0 && cw_addr === last + 24'h1) && k < 30000) begin
            @(posedge clk_sys);
            k++;
        end
        check(24'(k == 30000), 24'h0);
        repeat (2) @(posedge clk_sys);
        #1;
        check(24'(checksum), 24'(exp_sum));
        prot = 1'b1;
        #1;
        check(24'(checksum), 24'h0);
        check(24'(notes.size()), 24'h0);
        prot = 1'b0;
        clr = 1'b1;
        @(posedge clk_sys);
        #1;
        clr = 1'b0;
        check(24'(checksum), 24'h0);
        complete_run();
    end
endmodule // device_id_and_checksum_tb
`default_nettype wire
